// ---- bench/aas_probe_model.sv ----
// behavioural model of the four-connector thermal probe string
`timescale 1ns/1ps
module aas_probe_model
	import aas_pkg::*;
(
	// clock
	input wire logic pclk,
	// bench controls
	input wire logic [CONN_N*CNT_W-1:0] plug_cfg,
	input wire logic fault_req,
	input wire logic [1:0] kind_req,
	// far side of the block
	input wire logic [1:0] second_analog_output_range,
	output logic [1:0] sensor_kind_in,
	output logic [CONN_N*CNT_W-1:0] probe_count,
	output logic [CONN_N*POS_N*FLOW_W-1:0] sens_flow,
	output logic [CONN_N*POS_N*TEMP_W-1:0] sens_temp,
	output logic fault_in,
	output logic sw_current
);
	logic tog = 1'b0;
	always @(posedge pclk) begin
		tog <= ~tog;
	end
	assign sensor_kind_in = kind_req;
	assign probe_count = plug_cfg;
	assign fault_in = fault_req;
	assign sw_current = (second_analog_output_range == R_MA);
	// position 0 is the sensor at the tip; empty positions float and toggle
	always_comb begin
		for (int s = 0; s < CONN_N*POS_N; s++) begin
			if ((s % POS_N) < int'(plug_cfg[(s/POS_N)*CNT_W +: CNT_W])) begin
				sens_flow[s*FLOW_W +: FLOW_W] = FLOW_W'(1000 + 10*s);
				sens_temp[s*TEMP_W +: TEMP_W] = TEMP_W'(60 + s);
			end else begin
				sens_flow[s*FLOW_W +: FLOW_W] = {FLOW_W{tog}} ^ FLOW_W'(s);
				sens_temp[s*TEMP_W +: TEMP_W] = {TEMP_W{tog}} ^ TEMP_W'(s);
			end
		end
	end
endmodule : aas_probe_model

// ---- bench/airflow_alarm_sensor_addressing_test.sv ----
// self-checking bench of the airflow alarm and traverse block
`timescale 1ns/1ps
module airflow_alarm_sensor_addressing_test;
	import aas_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic e;
	} aas_reg_t;
	typedef struct packed {
		logic [2:0] kind;
		logic [FLOW_W-1:0] flow;
		logic flt;
		logic exp;
	} aas_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [FLOW_W-1:0] raw_flow = '0;
	logic fault_req = 1'b0;
	logic raw_valid = 1'b1;
	logic signed [TEMP_W-1:0] avg_temp = 10'sd70;
	logic [1:0] kind_req = ST_PROBE;
	logic [CONN_N*CNT_W-1:0] plug_cfg = 16'h0440;
	logic pready, pslverr, alarm_active, fault_in, sw_current, err;
	logic [DATA_W-1:0] prdata, rd;
	logic signed [DATA_W-1:0] flow_out;
	logic [DAC_W-1:0] second_analog_output_code;
	logic [1:0] second_analog_output_range, sensor_kind_in;
	logic [CONN_N*CNT_W-1:0] probe_count;
	logic [CONN_N*POS_N*FLOW_W-1:0] sens_flow;
	logic [CONN_N*POS_N*TEMP_W-1:0] sens_temp;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	aas_reg_t rst_rows[11] = '{'{A_CTRL, 32'h0000_00a2, 0}, '{A_GAIN, 32'h0000_03e8, 0}, '{A_OFS, 0, 0},
		'{A_FILT, 0, 0}, '{A_BUF, 32'h0000_001e, 0}, '{A_ALT, 0, 0}, '{A_TSC, 32'h00a0_ffec, 0},
		'{A_ASP, 0, 0}, '{A_HYS, 32'h0000_000f, 0}, '{A_DEL, 32'h0000_0005, 0}, '{A_TIDX, 32'h0000_0001, 0}};
	aas_reg_t bad_rows[18] = '{'{A_GAIN, 0, 1}, '{A_GAIN, 100000, 1}, '{A_OFS, 10000, 1}, '{A_FILT, 100, 1},
		'{A_BUF, 0, 1}, '{A_BUF, 1001, 1}, '{A_ALT, 18001, 1}, '{A_TSC, 32'h009b_0092, 1},
		'{A_TSC, 32'h0064_ffcd, 1}, '{A_ASP, 1000000, 1}, '{A_HYS, 100, 1}, '{A_DEL, 0, 1}, '{A_DEL, 901, 1},
		'{A_TIDX, 0, 1}, '{A_TIDX, 17, 1}, '{A_STAT, 0, 1}, '{A_FLOW, 0, 1}, '{8'h40, 0, 1}};
	aas_row_t rows[10] = '{'{AK_HI, 1000, 0, 1}, '{AK_HI, 100, 0, 0}, '{AK_LO, 100, 0, 1}, '{AK_LO, 1000, 0, 0},
		'{AK_BAND, 600, 0, 1}, '{AK_BAND, 500, 0, 0}, '{AK_BAND, 400, 0, 1}, '{AK_OFF, 1000, 1, 0},
		'{AK_FAULT, 500, 1, 1}, '{AK_FAULT, 500, 0, 0}};

	always #2.5 pclk = ~pclk;

	aas_core #(.TICKS_PER_SEC(20)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .raw_flow(raw_flow), .raw_valid(raw_valid), .avg_temp(avg_temp), .fault_in(fault_in),
		.sensor_kind_in(sensor_kind_in), .probe_count(probe_count), .sens_flow(sens_flow),
		.sens_temp(sens_temp), .flow_out(flow_out), .second_analog_output_code(second_analog_output_code), .second_analog_output_range(second_analog_output_range),
		.alarm_active(alarm_active));
	aas_probe_model pm (.pclk(pclk), .plug_cfg(plug_cfg), .fault_req(fault_req), .kind_req(kind_req),
		.second_analog_output_range(second_analog_output_range),
		.sensor_kind_in(sensor_kind_in), .probe_count(probe_count), .sens_flow(sens_flow),
		.sens_temp(sens_temp), .fault_in(fault_in), .sw_current(sw_current));

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// one apb transfer; request held until pready is sampled high at a rising edge
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic e);
		apb(1'b1, a, d);
		chk(err, e);
	endtask : wr

	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		apb(1'b0, a, '0);
		chk(rd, exp);
	endtask : rdc

	// two flow computations on consecutive edges, then the pipeline drains
	task automatic feed2(input logic [FLOW_W-1:0] a, input logic [FLOW_W-1:0] b);
		@(posedge pclk);
		raw_flow <= a;
		raw_valid <= 1'b1;
		@(posedge pclk);
		raw_flow <= b;
		@(posedge pclk);
		raw_valid <= 1'b0;
		repeat (6) @(posedge pclk);
		#1;
	endtask : feed2

	task automatic read_rst();
		for (int i = 0; i < 11; i++) rdc(rst_rows[i].a, rst_rows[i].d);
	endtask : read_rst

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			end_sim();
		end
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		read_rst();
		// temperature on the second output, mid scale and both clamps
		chk(second_analog_output_code, 32'h0000_9999);
		avg_temp <= -10'sd30;
		repeat (2) @(posedge pclk);
		#1;
		chk(second_analog_output_code, DAC_4MA);
		avg_temp <= 10'sd200;
		repeat (2) @(posedge pclk);
		#1;
		chk(second_analog_output_code, DAC_FULL);
		for (int i = 0; i < 18; i++) wr(bad_rows[i].a, bad_rows[i].d, bad_rows[i].e);
		read_rst();
		rdc(8'h40, 0);
		wr(A_BUF, 1000, 0);
		rdc(A_BUF, 1000);
		wr(A_TSC, 32'h00a0_0096, 0);
		rdc(A_TSC, 32'h00a0_0096);
		// traverse with probes on the middle connectors
		rdc(A_THDR, 32'h0800_4400);
		wr(A_TIDX, 1, 0);
		rdc(A_TFLOW, 32'h3100_0438);
		rdc(A_TTEMP, 32'h3100_0044);
		wr(A_TIDX, 5, 0);
		rdc(A_TFLOW, 32'h3500_0488);
		wr(A_TIDX, 9, 0);
		rdc(A_TFLOW, 0);
		plug_cfg <= 16'h0048;
		repeat (300) @(posedge pclk);
		rdc(A_THDR, 32'h0c00_0480);
		rdc(A_TFLOW, 32'h3900_0438);
		wr(A_TIDX, 10, 0);
		rdc(A_TFLOW, 32'h4100_0442);
		// fan sensors: one per connector at most
		kind_req <= ST_FAN;
		repeat (30) @(posedge pclk);
		rdc(A_THDR, 32'h0200_0111);
		rdc(A_TFLOW, 0);
		wr(A_TIDX, 2, 0);
		rdc(A_TFLOW, 32'h3200_0438);
		// alarm kinds with a one second persistence
		wr(A_BUF, 1, 0);
		wr(A_DEL, 1, 0);
		wr(A_ASP, 500, 0);
		for (int i = 0; i < 10; i++) begin
			wr(A_CTRL, 32'h0000_00b0 | {rows[i].kind, 1'b0}, 0);
			raw_flow <= rows[i].flow;
			fault_req <= rows[i].flt;
			repeat (60) @(posedge pclk);
			#1;
			chk(alarm_active, rows[i].exp);
			chk(second_analog_output_code, rows[i].exp ? DATA_W'(DAC_FULL) : DATA_W'(DAC_4MA));
			chk(flow_out, rows[i].flow);
		end
		chk(second_analog_output_range, 2);
		chk(sw_current, 1);
		wr(A_CTRL, 32'h0000_0094, 0);
		raw_flow <= 1000;
		repeat (60) @(posedge pclk);
		#1;
		chk(second_analog_output_code, DAC_4MA);
		// gain, correction term and altitude
		wr(A_CTRL, 32'h0000_00b1, 0);
		wr(A_GAIN, 2000, 0);
		wr(A_OFS, 32'hffff_ff9c, 0);
		repeat (20) @(posedge pclk);
		#1;
		chk(flow_out, 1900);
		wr(A_ALT, 18000, 0);
		repeat (20) @(posedge pclk);
		#1;
		chk(flow_out, 2943);
		// high alarm whose persistence is broken once
		wr(A_ALT, 0, 0);
		wr(A_GAIN, 1000, 0);
		wr(A_OFS, 0, 0);
		wr(A_CTRL, 32'h0000_00b4, 0);
		raw_flow <= 100;
		repeat (40) @(posedge pclk);
		raw_flow <= 1000;
		repeat (15) @(posedge pclk);
		raw_flow <= 100;
		repeat (5) @(posedge pclk);
		raw_flow <= 1000;
		repeat (15) @(posedge pclk);
		#1;
		chk(alarm_active, 0);
		for (int n = 0; n < 40 && alarm_active !== 1'b1; n++) begin
			@(posedge pclk);
			#1;
		end
		chk(alarm_active, 1);
		// two-sample mean, then damping at half strength
		@(posedge pclk);
		raw_valid <= 1'b0;
		repeat (4) @(posedge pclk);
		wr(A_BUF, 2, 0);
		feed2(100, 300);
		chk(flow_out, 200);
		wr(A_FILT, 50, 0);
		feed2(600, 600);
		chk(flow_out, 400);
		// reset in mid-run clears the outputs
		@(posedge pclk);
		presetn <= 1'b0;
		#1;
		chk(alarm_active, 0);
		chk(second_analog_output_code, 0);
		chk(flow_out, 0);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdc(A_CTRL, 32'h0000_00a2);
		end_sim();
	end
endmodule : airflow_alarm_sensor_addressing_test

// ---- core/aas_core.sv ----
// airflow conditioning, alarm, second output and sensor traverse block with apb registers
`timescale 1ns/1ps
// Notes on behaviour
// - optional flow multiplier 0.001 to 99.999
// - optional signed correction term -9999..9999
// - damping filter 0 to 99 percent
// - mean of 1..1000 computations, default 30
// - altitude correction 0..18000 ft, default 0
// - second output: temperature or alarm
// - low temp endpoint -50..150, below high-10
// - high temp endpoint -40..160, above low+10
// - band alarm outside set point plus/minus hysteresis
// - high alarm above, low alarm below point
// - fault alarm on faults; off disables alarm
// - set point flow or pressure range, default 0
// - hysteresis percent symmetric, default 15
// - alarm after 1..900 s persistence, default 5
// - alarm drives output to max or min
// - traverse: type, four counts, readings
// - counts 0..8 probe, 0..1 fan/bleed
// - readings from every used connector, selectable units
// - leftmost used connector holds first sensors
// - sixteen sensors labelled 1-9 then A-G
// - replugged probe renumbered within 15 s
module aas_core
	import aas_pkg::*;
#(
	parameter int TICKS_PER_SEC = TICKS_SEC_DEF
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DATA_W-1:0] pwdata,
	output logic pready,
	output logic [DATA_W-1:0] prdata,
	output logic pslverr,
	// measurement inputs
	input wire logic [FLOW_W-1:0] raw_flow,
	input wire logic raw_valid,
	input wire logic signed [TEMP_W-1:0] avg_temp,
	input wire logic fault_in,
	// probe discovery
	input wire logic [1:0] sensor_kind_in,
	input wire logic [CONN_N*CNT_W-1:0] probe_count,
	input wire logic [CONN_N*POS_N*FLOW_W-1:0] sens_flow,
	input wire logic [CONN_N*POS_N*TEMP_W-1:0] sens_temp,
	// results
	output logic signed [DATA_W-1:0] flow_out,
	output logic [DAC_W-1:0] second_analog_output_code,
	output logic [1:0] second_analog_output_range,
	output logic alarm_active
);
	localparam int TW = $clog2(TICKS_PER_SEC + 1);

	if (TICKS_PER_SEC < 2) begin : g_chk
		$error("TICKS_PER_SEC must be at least 2");
	end

	aas_cfg_t cfg_q;
	logic pready_q;
	logic pslverr_q;
	logic [DATA_W-1:0] prdata_q;
	logic [DATA_W-1:0] rd_d;
	logic bad_d;
	logic [IDX_W-1:0] tidx_q;
	logic signed [DATA_W-1:0] c1_q;
	logic signed [DATA_W-1:0] c2_q;
	logic v1_q;
	logic v2_q;
	logic signed [47:0] sum_q;
	logic [BUF_BW-1:0] n_q;
	logic signed [DATA_W-1:0] mean_q;
	logic mv_q;
	logic signed [DATA_W-1:0] flow_q;
	logic cond;
	logic alarm_q;
	logic [TW-1:0] acyc_q;
	logic [DEL_BW-1:0] pers_q;
	logic [DAC_W-1:0] second_analog_output_q;
	logic [DAC_W-1:0] lo_code;
	logic [DAC_W-1:0] hi_code;
	logic [DAC_W-1:0] temp_code;
	logic [TW-1:0] scyc_q;
	logic seen_q;
	logic [CNT_W-1:0] cnt_q [CONN_N];
	aas_stype_t stype_q;
	aas_stype_t stype_in;
	logic [DATA_W-1:0] hdr;
	logic [RD_W-1:0] tflow;
	logic [RD_W-1:0] ttemp;
	logic [7:0] label;
	logic signed [DATA_W-1:0] wv;
	logic signed [HALF_W-1:0] w_lo;
	logic signed [HALF_W-1:0] w_hi;
	aas_ctrl_t w_ctrl;
	aas_stat_t stat;

	wire acc_go = psel && penable && !pready_q;
	wire done = psel && penable && pready_q;
	wire wr_ok = done && pwrite && !pslverr_q;

	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign flow_out = flow_q;
	assign second_analog_output_code = second_analog_output_q;
	assign second_analog_output_range = cfg_q.ctrl.rng;
	assign alarm_active = alarm_q;
	assign stype_in = (sensor_kind_in == ST_FAN) ? ST_FAN : (sensor_kind_in == ST_BLEED) ? ST_BLEED : ST_PROBE;
	assign stat = '{pers: pers_q, fault: fault_in, cond: cond, alarm: alarm_q};

	// read mux and write legality, both taken in the first access cycle
	always_comb begin
		wv = $signed(pwdata);
		w_lo = $signed(pwdata[HALF_W-1:0]);
		w_hi = $signed(pwdata[DATA_W-1:HALF_W]);
		w_ctrl = aas_ctrl_t'(pwdata[CTRL_W-1:0]);
		rd_d = '0;
		bad_d = 1'b0;
		case (paddr)
			A_CTRL: begin
				rd_d = DATA_W'(cfg_q.ctrl);
				bad_d = pwrite && (w_ctrl.kind > AK_FAULT || w_ctrl.rng > R_MA);
			end
			A_GAIN: begin
				rd_d = DATA_W'(cfg_q.gain);
				bad_d = pwrite && (wv < GAIN_MIN || wv > GAIN_MAX);
			end
			A_OFS: begin
				rd_d = DATA_W'(cfg_q.offset);
				bad_d = pwrite && (wv < -OFS_LIM || wv > OFS_LIM);
			end
			A_FILT: begin
				rd_d = DATA_W'(cfg_q.filter);
				bad_d = pwrite && (wv < 0 || wv > FILT_MAX);
			end
			A_BUF: begin
				rd_d = DATA_W'(cfg_q.buf_n);
				bad_d = pwrite && (wv < BUF_MIN || wv > BUF_MAX);
			end
			A_ALT: begin
				rd_d = DATA_W'(cfg_q.site_elevation);
				bad_d = pwrite && (wv < 0 || wv > ALT_MAX);
			end
			A_TSC: begin
				rd_d = {HALF_W'(cfg_q.t_high), HALF_W'(cfg_q.t_low)};
				bad_d = pwrite && (w_lo < TL_MIN || w_lo > TL_MAX
					|| w_hi < TH_MIN || w_hi > TH_MAX || w_hi - w_lo < T_SPAN);
			end
			A_ASP: begin
				rd_d = DATA_W'(cfg_q.alarm_threshold);
				bad_d = pwrite && (cfg_q.ctrl.pressure ? (wv < -ASP_P_LIM || wv > ASP_P_LIM)
					: (wv < 0 || wv > ASP_MAX));
			end
			A_HYS: begin
				rd_d = DATA_W'(cfg_q.hys);
				bad_d = pwrite && (wv < 0 || wv > HYS_MAX);
			end
			A_DEL: begin
				rd_d = DATA_W'(cfg_q.delay);
				bad_d = pwrite && (wv < DEL_MIN || wv > DEL_MAX);
			end
			A_STAT: begin
				rd_d = DATA_W'(stat);
				bad_d = pwrite;
			end
			A_FLOW: begin
				rd_d = flow_q;
				bad_d = pwrite;
			end
			A_THDR: begin
				rd_d = hdr;
				bad_d = pwrite;
			end
			A_TIDX: begin
				rd_d = DATA_W'(tidx_q);
				bad_d = pwrite && (wv < 1 || wv > SENS_MAX);
			end
			A_TFLOW: begin
				rd_d = {label, tflow};
				bad_d = pwrite;
			end
			A_TTEMP: begin
				rd_d = {label, ttemp};
				bad_d = pwrite;
			end
			default: begin
				rd_d = '0;
				bad_d = 1'b1;
			end
		endcase
	end

	// apb answer: one wait state, data and error held for the completing cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= acc_go;
			if (acc_go) begin
				pslverr_q <= bad_d;
				prdata_q <= pwrite ? '0 : rd_d;
			end else if (done) begin
				pslverr_q <= 1'b0;
				prdata_q <= '0;
			end
		end
	end

	// configuration registers; refused writes leave the old value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= CFG_RST;
			tidx_q <= IDX_RST;
		end else if (wr_ok) begin
			case (paddr)
				A_CTRL: cfg_q.ctrl <= w_ctrl;
				A_GAIN: cfg_q.gain <= pwdata[GAIN_BW-1:0];
				A_OFS: cfg_q.offset <= $signed(pwdata[OFS_BW-1:0]);
				A_FILT: cfg_q.filter <= pwdata[FILT_BW-1:0];
				A_BUF: cfg_q.buf_n <= pwdata[BUF_BW-1:0];
				A_ALT: cfg_q.site_elevation <= pwdata[ALT_BW-1:0];
				A_TSC: begin
					cfg_q.t_low <= TS_BW'(w_lo);
					cfg_q.t_high <= TS_BW'(w_hi);
				end
				A_ASP: cfg_q.alarm_threshold <= $signed(pwdata[ASP_BW-1:0]);
				A_HYS: cfg_q.hys <= pwdata[FILT_BW-1:0];
				A_DEL: cfg_q.delay <= pwdata[DEL_BW-1:0];
				A_TIDX: tidx_q <= pwdata[IDX_W-1:0];
				default: ;
			endcase
		end
	end

	// correction pipeline: gain/offset, then altitude, then averaging, then damping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			v1_q <= 1'b0;
			v2_q <= 1'b0;
			c1_q <= '0;
			c2_q <= '0;
		end else begin
			v1_q <= raw_valid;
			v2_q <= v1_q;
			if (raw_valid) begin
				c1_q <= cfg_q.ctrl.corr_en ? DATA_W'(longint'(raw_flow) * longint'(cfg_q.gain) / GAIN_ONE
					+ longint'(cfg_q.offset)) : DATA_W'(raw_flow);
			end
			if (v1_q) begin
				c2_q <= DATA_W'((longint'(c1_q) * longint'(ALT_ONE + int'(cfg_q.site_elevation) * ALT_K)) >>> ALT_SH);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum_q <= '0;
			n_q <= '0;
			mean_q <= '0;
			mv_q <= 1'b0;
		end else begin
			mv_q <= 1'b0;
			if (v2_q) begin
				if (n_q + 1'b1 >= cfg_q.buf_n) begin
					mean_q <= DATA_W'((sum_q + 48'(c2_q)) / $signed(48'(cfg_q.buf_n)));
					mv_q <= 1'b1;
					sum_q <= '0;
					n_q <= '0;
				end else begin
					sum_q <= sum_q + 48'(c2_q);
					n_q <= n_q + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flow_q <= '0;
		end else if (mv_q) begin
			flow_q <= DATA_W'((longint'(cfg_q.filter) * longint'(flow_q)
				+ longint'(PCT - int'(cfg_q.filter)) * longint'(mean_q)) / PCT);
		end
	end

	// alarm condition on the fully corrected flow
	always_comb begin
		longint a;
		longint h;
		a = longint'(cfg_q.alarm_threshold);
		h = (a < 0 ? -a : a) * longint'(cfg_q.hys) / PCT;
		unique case (cfg_q.ctrl.kind)
			AK_BAND: cond = longint'(flow_q) > a + h || longint'(flow_q) < a - h;
			AK_HI: cond = longint'(flow_q) > a;
			AK_LO: cond = longint'(flow_q) < a;
			AK_FAULT: cond = fault_in;
			default: cond = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acyc_q <= '0;
			pers_q <= '0;
			alarm_q <= 1'b0;
		end else begin
			alarm_q <= cond && pers_q >= cfg_q.delay;
			if (!cond) begin
				acyc_q <= '0;
				pers_q <= '0;
			end else if (acyc_q == TW'(TICKS_PER_SEC - 1)) begin
				acyc_q <= '0;
				if (pers_q != DEL_BW'(DEL_MAX)) begin
					pers_q <= pers_q + 1'b1;
				end
			end else begin
				acyc_q <= acyc_q + 1'b1;
			end
		end
	end

	// second analog output: limits follow the selected range
	always_comb begin
		longint t;
		longint s;
		t = longint'(avg_temp) - longint'(cfg_q.t_low);
		s = longint'(cfg_q.t_high) - longint'(cfg_q.t_low);
		unique case (cfg_q.ctrl.rng)
			R_5V: begin
				lo_code = '0;
				hi_code = DAC_W'(DAC_HALF);
			end
			R_MA: begin
				lo_code = DAC_W'(DAC_4MA);
				hi_code = DAC_W'(DAC_FULL);
			end
			default: begin
				lo_code = '0;
				hi_code = DAC_W'(DAC_FULL);
			end
		endcase
		if (t <= 0) begin
			temp_code = lo_code;
		end else if (t >= s) begin
			temp_code = hi_code;
		end else begin
			temp_code = DAC_W'(longint'(lo_code) + t * longint'(hi_code - lo_code) / s);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			second_analog_output_q <= '0;
		end else if (cfg_q.ctrl.second_analog_output_alarm) begin
			second_analog_output_q <= (alarm_q == cfg_q.ctrl.drive_max) ? hi_code : lo_code;
		end else begin
			second_analog_output_q <= temp_code;
		end
	end

	// probe discovery: latched right after reset, then once a second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scyc_q <= '0;
			seen_q <= 1'b0;
			stype_q <= ST_PROBE;
		end else begin
			seen_q <= 1'b1;
			scyc_q <= (scyc_q == TW'(TICKS_PER_SEC - 1)) ? '0 : scyc_q + 1'b1;
			if (!seen_q || scyc_q == TW'(TICKS_PER_SEC - 1)) begin
				stype_q <= stype_in;
			end
		end
	end

	for (genvar i = 0; i < CONN_N; i++) begin : g_conn
		wire [CNT_W-1:0] raw_c = probe_count[i*CNT_W +: CNT_W];
		wire [CNT_W-1:0] lim_c = (stype_in == ST_PROBE) ? CNT_W'(PROBE_MAX) : CNT_W'(SINGLE_MAX);
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_q[i] <= '0;
			end else if (!seen_q || scyc_q == TW'(TICKS_PER_SEC - 1)) begin
				cnt_q[i] <= (raw_c > lim_c) ? lim_c : raw_c;
			end
		end
	end

	// traverse header and the reading picked by the sensor index
	always_comb begin
		int base;
		int hit;
		int pos;
		longint f;
		longint tc;
		base = 0;
		hit = -1;
		pos = 0;
		f = 0;
		tc = 0;
		hdr = DATA_W'(stype_q);
		for (int i = 0; i < CONN_N; i++) begin
			hdr[(i+1)*CNT_W +: CNT_W] = cnt_q[i];
			if (int'(tidx_q) > base && int'(tidx_q) <= base + int'(cnt_q[i])) begin
				hit = i;
				pos = int'(tidx_q) - base - 1;
			end
			base = base + int'(cnt_q[i]);
		end
		hdr[HDR_TOT +: IDX_W] = IDX_W'(base);
		if (hit < 0) begin
			tflow = '0;
			ttemp = '0;
			label = '0;
		end else begin
			f = longint'(sens_flow[(hit*POS_N+pos)*FLOW_W +: FLOW_W]);
			tc = longint'($signed(sens_temp[(hit*POS_N+pos)*TEMP_W +: TEMP_W]));
			tflow = RD_W'(cfg_q.ctrl.metric ? f * MS_NUM / MS_DEN : f);
			ttemp = RD_W'(cfg_q.ctrl.metric ? (tc - F_ZERO) * C_NUM / C_DEN : tc);
			label = (int'(tidx_q) <= DIGIT_LAST) ? ASCII_ONE + 8'(tidx_q - 1'b1)
				: ASCII_A + 8'(tidx_q - IDX_W'(DIGIT_LAST + 1));
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_gain_wr;
		(wr_ok && paddr == A_GAIN) |=> cfg_q.gain == $past(pwdata[GAIN_BW-1:0]);
	endproperty
	a_gain_wr: assert property (p_gain_wr) else $error("gain write not taken");

	property p_ofs_rng;
		cfg_q.offset >= -OFS_LIM && cfg_q.offset <= OFS_LIM;
	endproperty
	a_ofs_rng: assert property (p_ofs_rng) else $error("offset out of range");

	property p_nofilt;
		(mv_q && cfg_q.filter == 0) |=> flow_q == $past(mean_q);
	endproperty
	a_nofilt: assert property (p_nofilt) else $error("undamped flow differs from mean");

	property p_block;
		(v2_q && n_q + 1'b1 >= cfg_q.buf_n) |=> mv_q && n_q == 0;
	endproperty
	a_block: assert property (p_block) else $error("average block not closed");

	property p_span;
		cfg_q.t_high - cfg_q.t_low >= T_SPAN && cfg_q.t_low >= TL_MIN && cfg_q.t_high <= TH_MAX;
	endproperty
	a_span: assert property (p_span) else $error("temperature scale invalid");

	property p_hi;
		(cfg_q.ctrl.kind == AK_HI && flow_q <= cfg_q.alarm_threshold) |=> !alarm_q;
	endproperty
	a_hi: assert property (p_hi) else $error("high alarm at or below set point");

	property p_off;
		cfg_q.ctrl.kind == AK_OFF |=> !alarm_q;
	endproperty
	a_off: assert property (p_off) else $error("alarm while disabled");

	property p_delay;
		$rose(alarm_q) |-> $past(pers_q) >= $past(cfg_q.delay) && $past(cond);
	endproperty
	a_delay: assert property (p_delay) else $error("alarm before delay");

	property p_drive;
		(cfg_q.ctrl.second_analog_output_alarm && alarm_q && cfg_q.ctrl.drive_max) |=> second_analog_output_q == $past(hi_code);
	endproperty
	a_drive: assert property (p_drive) else $error("alarm output not at maximum");

	property p_single;
		stype_q != ST_PROBE |-> cnt_q[0] <= SINGLE_MAX && cnt_q[1] <= SINGLE_MAX
			&& cnt_q[2] <= SINGLE_MAX && cnt_q[3] <= SINGLE_MAX;
	endproperty
	a_single: assert property (p_single) else $error("single sensor count above one");

	property p_restart;
		!cond |=> pers_q == 0 && acyc_q == 0;
	endproperty
	a_restart: assert property (p_restart) else $error("persistence not restarted");
endmodule : aas_core

// ---- core/aas_pkg.sv ----
// package: constants, register map and config layout of the airflow alarm block
package aas_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int HALF_W = 16;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_GAIN = 8'h04;
	localparam logic [7:0] A_OFS = 8'h08;
	localparam logic [7:0] A_FILT = 8'h0c;
	localparam logic [7:0] A_BUF = 8'h10;
	localparam logic [7:0] A_ALT = 8'h14;
	localparam logic [7:0] A_TSC = 8'h18;
	localparam logic [7:0] A_ASP = 8'h1c;
	localparam logic [7:0] A_HYS = 8'h20;
	localparam logic [7:0] A_DEL = 8'h24;
	localparam logic [7:0] A_STAT = 8'h28;
	localparam logic [7:0] A_FLOW = 8'h2c;
	localparam logic [7:0] A_THDR = 8'h30;
	localparam logic [7:0] A_TIDX = 8'h34;
	localparam logic [7:0] A_TFLOW = 8'h38;
	localparam logic [7:0] A_TTEMP = 8'h3c;
	localparam int GAIN_MIN = 1, GAIN_MAX = 99999, GAIN_ONE = 1000, OFS_LIM = 9999;
	localparam int FILT_MAX = 99, PCT = 100, BUF_MIN = 1, BUF_MAX = 1000, BUF_DEF = 30;
	localparam int ALT_MAX = 18000, ALT_K = 2, ALT_SH = 16, ALT_ONE = 65536;
	localparam int TL_MIN = -50, TL_MAX = 150, TH_MIN = -40, TH_MAX = 160, T_SPAN = 10;
	localparam int TL_DEF = -20, TH_DEF = 160;
	localparam int ASP_MAX = 999999, ASP_P_LIM = 9999, HYS_MAX = 99, HYS_DEF = 15;
	localparam int DEL_MIN = 1, DEL_MAX = 900, DEL_DEF = 5, REDETECT_S = 15;
	localparam int CONN_N = 4, POS_N = 8, SENS_MAX = 16, PROBE_MAX = 8, SINGLE_MAX = 1;
	localparam int CNT_W = 4, IDX_W = 5, FLOW_W = 20, TEMP_W = 10, DAC_W = 16, RD_W = 24;
	localparam int DAC_FULL = 65535, DAC_HALF = 32767, DAC_4MA = 13107;
	localparam int MS_NUM = 508, MS_DEN = 100, F_ZERO = 32, C_NUM = 5, C_DEN = 9;
	localparam int DIGIT_LAST = 9, LBL_POS = 24, HDR_TOT = 24;
	localparam logic [7:0] ASCII_ONE = 8'h31;
	localparam logic [7:0] ASCII_A = 8'h41;
	localparam int SEC_NS = 1000000000, CLK_NS = 5;
	localparam int TICKS_SEC_DEF = SEC_NS / CLK_NS;
	localparam int GAIN_BW = 17, OFS_BW = 15, FILT_BW = 7, BUF_BW = 10, ALT_BW = 15;
	localparam int TS_BW = 9, ASP_BW = 21, DEL_BW = 10, CTRL_W = 10;

	typedef enum logic [2:0] {AK_OFF = 3'h0, AK_BAND = 3'h1, AK_HI = 3'h2, AK_LO = 3'h3, AK_FAULT = 3'h4} aas_kind_t;
	typedef enum logic [1:0] {R_10V = 2'h0, R_5V = 2'h1, R_MA = 2'h2} aas_range_t;
	typedef enum logic [1:0] {ST_PROBE = 2'h0, ST_FAN = 2'h1, ST_BLEED = 2'h2} aas_stype_t;

	typedef struct packed {
		logic pressure;
		logic metric;
		aas_range_t rng;
		logic drive_max;
		logic second_analog_output_alarm;
		aas_kind_t kind;
		logic corr_en;
	} aas_ctrl_t;

	typedef struct packed {
		aas_ctrl_t ctrl;
		logic [GAIN_BW-1:0] gain;
		logic signed [OFS_BW-1:0] offset;
		logic [FILT_BW-1:0] filter;
		logic [BUF_BW-1:0] buf_n;
		logic [ALT_BW-1:0] site_elevation;
		logic signed [TS_BW-1:0] t_low;
		logic signed [TS_BW-1:0] t_high;
		logic signed [ASP_BW-1:0] alarm_threshold;
		logic [FILT_BW-1:0] hys;
		logic [DEL_BW-1:0] delay;
	} aas_cfg_t;

	typedef struct packed {
		logic [DEL_BW-1:0] pers;
		logic fault;
		logic cond;
		logic alarm;
	} aas_stat_t;

	localparam aas_cfg_t CFG_RST = '{
		ctrl: '{pressure: 1'b0, metric: 1'b0, rng: R_MA, drive_max: 1'b1,
			second_analog_output_alarm: 1'b0, kind: AK_BAND, corr_en: 1'b0},
		gain: GAIN_BW'(GAIN_ONE), offset: '0, filter: '0, buf_n: BUF_BW'(BUF_DEF),
		site_elevation: '0, t_low: TS_BW'(TL_DEF), t_high: TS_BW'(TH_DEF), alarm_threshold: '0,
		hys: FILT_BW'(HYS_DEF), delay: DEL_BW'(DEL_DEF)};
	localparam logic [IDX_W-1:0] IDX_RST = 5'h01;
endpackage : aas_pkg
